// ==== logic/adc_control_interface.sv ====
/*
 Converter control logic: control and result registers over APB, the
 successive-approximation sequencer, the end-of-conversion flag and
 its interrupt. Assumes an analog comparator answering on comp_high
 within one step time, and wait/stop mode levels from the core.

*/
module adc_control_interface
   import adc_ctrl_pkg::*;
#(
   parameter int step_cycles = bit_cycles
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comp_high,
   input wire logic wait_mode,
   input wire logic stop_mode,
   output logic [7:0] dac_code,
   output logic converter_power,
   output logic main_osc_disable,
   output logic conv_irq,
   output logic wake_request
);
   // =====================================================
   // Bus decode
   wire logic access = psel && penable;
   wire logic hit_result = (paddr[9:0] == result_addr) && (paddr[31:10] == 22'h000000);
   wire logic hit_control = (paddr[9:0] == control_addr) && (paddr[31:10] == 22'h000000);
   wire logic ctrl_write = access && pwrite && hit_control && pstrb[0];
   wire logic start_write = ctrl_write && pwdata[start_bit];

   // =====================================================
   // Registers
   ctrl_fields_s ctrl_reg;
   logic done_reg;
   logic [7:0] result_reg;
   conv_state_e state_reg;
   logic [7:0] trial_reg;
   logic [7:0] mask_reg;
   logic [15:0] step_count_reg;
   logic comp_meta_reg;
   logic comp_sync_reg;

   // Comparator is analog-side; resynchronise before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         comp_meta_reg <= 1'b0;
         comp_sync_reg <= 1'b0;
      end else begin
         comp_meta_reg <= comp_high;
         comp_sync_reg <= comp_meta_reg;
      end
   end

   // Limitation: the comparator answer needs two flops plus one cycle, so step_cycles below 3
   // would decide each bit on the previous trial's answer

   wire logic enabled = ctrl_reg.power_on && !stop_mode;
   wire logic step_done = (step_count_reg == 16'(step_cycles - 1));
   wire logic last_step = step_done && mask_reg[0];
   wire logic finish = (state_reg == st_convert) && enabled && last_step && !start_write;
   wire logic [7:0] decided = comp_sync_reg ? (trial_reg & ~mask_reg) : trial_reg;

   // Control register; done flag set only by hardware
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_reg <= '0;
         done_reg <= control_reset[done_flag_bit];
      end else begin
         if (ctrl_write) begin
            ctrl_reg.irq_enable <= pwdata[irq_enable_bit];
            ctrl_reg.power_on <= pwdata[power_on_bit];
            ctrl_reg.osc_disable <= pwdata[osc_disable_bit];
         end
         if (start_write && enabled) begin
            done_reg <= 1'b0;
         end else if (finish) begin
            done_reg <= 1'b1;
         end
      end
   end

   // =====================================================
   // Control register checks
   sequence ctrl_written;
      ctrl_write;
   endsequence

   sequence start_blocked;
      start_write && !enabled;
   endsequence

   // Writes reach the flag only through a start; a zero written to it is refused
   enable_bit_a: assert property (@(posedge clock) disable iff (rst)
      ctrl_written |=> ctrl_reg.irq_enable == $past(pwdata[irq_enable_bit]))
      else $error("enable bit not written");
   power_pin_a: assert property (@(posedge clock) disable iff (rst)
      ctrl_written |=> converter_power == $past(pwdata[power_on_bit]))
      else $error("power bit not written");
   osc_bit_a: assert property (@(posedge clock) disable iff (rst)
      ctrl_written |=> main_osc_disable == $past(pwdata[osc_disable_bit]))
      else $error("oscillator bit not written");
   no_clear_a: assert property (@(posedge clock) disable iff (rst)
      (done_reg && ctrl_write && !pwdata[start_bit]) |=> done_reg)
      else $error("done flag cleared by a write");
   irq_off_a: assert property (@(posedge clock) disable iff (rst)
      (ctrl_write && !pwdata[irq_enable_bit]) |=> !conv_irq)
      else $error("interrupt stayed with enable cleared");
   power_gate_a: assert property (@(posedge clock) disable iff (rst)
      start_blocked |=> (state_reg == st_idle && done_reg == $past(done_reg)))
      else $error("start acted while disabled");
   bad_write_a: assert property (@(posedge clock) disable iff (rst)
      (access && pwrite && !hit_control) |=> $stable(ctrl_reg))
      else $error("control changed by a stray write");
   done_set_only_a: assert property (@(posedge clock) disable iff (rst)
      (!done_reg && !finish) |=> !done_reg)
      else $error("done flag set without completion");
   reset_value_a: assert property (@(posedge clock) rst |=> control_view == control_reset)
      else $error("control reset value wrong");

   // Sequencer: one trial bit per step, MSB first; no auto-repeat
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= st_idle;
         trial_reg <= 8'h00;
         mask_reg <= 8'h00;
         step_count_reg <= 16'h0000;
         result_reg <= result_reset;
      end else begin
         case (state_reg)
            st_idle: begin
               if (start_write && enabled) begin
                  state_reg <= st_convert;
                  trial_reg <= 8'h80;
                  mask_reg <= 8'h80;
                  step_count_reg <= 16'h0000;
               end
            end
            st_convert: begin
               if (!enabled) begin
                  state_reg <= st_idle;
               end else if (start_write) begin
                  trial_reg <= 8'h80;
                  mask_reg <= 8'h80;
                  step_count_reg <= 16'h0000;
               end else if (step_done) begin
                  step_count_reg <= 16'h0000;
                  if (mask_reg[0]) begin
                     result_reg <= decided;
                     state_reg <= st_idle;
                  end else begin
                     trial_reg <= decided | (mask_reg >> 1);
                     mask_reg <= mask_reg >> 1;
                  end
               end else begin
                  step_count_reg <= step_count_reg + 16'h0001;
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // =====================================================
   // Sequencer checks
   sequence conv_running;
      state_reg == st_convert && enabled && !start_write;
   endsequence

   // Restart and stop both win over completion in the same cycle
   power_off_idle_a: assert property (@(posedge clock) disable iff (rst)
      !enabled |=> state_reg == st_idle)
      else $error("sequencer ran while disabled");
   wait_runs_a: assert property (@(posedge clock) disable iff (rst)
      conv_running ##0 (wait_mode && !last_step) |=> state_reg == st_convert)
      else $error("wait mode stopped a conversion");
   zero_start_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == st_idle && ctrl_write && !pwdata[start_bit]) |=> state_reg == st_idle)
      else $error("zero start bit began a conversion");
   first_trial_a: assert property (@(posedge clock) disable iff (rst)
      (start_write && enabled) |=> dac_code == 8'h80)
      else $error("conversion did not start at mid code");
   mask_walk_a: assert property (@(posedge clock) disable iff (rst)
      conv_running ##0 (step_done && !mask_reg[0]) |=> mask_reg == ($past(mask_reg) >> 1))
      else $error("trial bit did not advance");
   result_hold_a: assert property (@(posedge clock) disable iff (rst)
      !finish |=> $stable(result_reg))
      else $error("result changed without completion");
   step_hold_a: assert property (@(posedge clock) disable iff (rst)
      conv_running ##0 (!step_done) |=> $stable(trial_reg))
      else $error("trial changed inside a step");
   stop_start_a: assert property (@(posedge clock) disable iff (rst)
      (start_write && stop_mode) |=> state_reg == st_idle)
      else $error("start acted in stop mode");
   restart_mid_a: assert property (@(posedge clock) disable iff (rst)
      conv_running ##1 (start_write && enabled) |=> (state_reg == st_convert && step_count_reg == 16'h0000))
      else $error("restart did not begin afresh");

   // =====================================================
   // Read data and outputs
   wire logic [7:0] control_view = {ctrl_reg.irq_enable, done_reg, 1'b0, ctrl_reg.power_on,
                                    1'b0, ctrl_reg.osc_disable, 2'b00};
   logic [31:0] rdata_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_result) begin
            rdata_reg <= {24'h000000, result_reg};
         end else if (hit_control) begin
            rdata_reg <= {24'h000000, control_view};
         end else begin
            rdata_reg <= 32'h00000000;
         end
      end
   end

   assign prdata = rdata_reg;
   assign pready = 1'b1;
   assign pslverr = access && !(hit_result || hit_control);
   assign dac_code = trial_reg;
   assign converter_power = ctrl_reg.power_on;
   assign main_osc_disable = ctrl_reg.osc_disable;
   assign conv_irq = done_reg && ctrl_reg.irq_enable;
   assign wake_request = conv_irq && wait_mode && !stop_mode;

   // =====================================================
   // Checks
   sequence start_seen;
      start_write && enabled;
   endsequence

   sequence control_fetch;
      psel && !penable && !pwrite && hit_control;
   endsequence

   sequence result_fetch;
      psel && !penable && !pwrite && hit_result;
   endsequence

   // Start beats completion in one cycle, so a late restart never reports a stale result
   start_clears_a: assert property (@(posedge clock) disable iff (rst) start_seen |=> !done_reg)
      else $error("start did not clear done flag");
   irq_level_a: assert property (@(posedge clock) disable iff (rst)
      (conv_irq && !ctrl_write) |=> conv_irq)
      else $error("interrupt level dropped on its own");
   done_sticky_a: assert property (@(posedge clock) disable iff (rst)
      (done_reg && !$past(rst) && !(start_write && enabled)) |=> done_reg)
      else $error("done flag cleared without start");
   finish_sets_a: assert property (@(posedge clock) disable iff (rst) finish |=> done_reg)
      else $error("completion did not set flag");
   result_load_a: assert property (@(posedge clock) disable iff (rst)
      finish |=> result_reg == $past(decided))
      else $error("result not loaded at completion");
   stop_halts_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == st_convert && !enabled) |=> state_reg == st_idle)
      else $error("conversion continued while disabled");
   restart_a: assert property (@(posedge clock) disable iff (rst)
      start_seen |=> (state_reg == st_convert && mask_reg == 8'h80))
      else $error("start did not restart conversion");
   start_reads_zero_a: assert property (@(posedge clock) disable iff (rst)
      control_fetch |=> !prdata[start_bit])
      else $error("start bit read nonzero");
   no_repeat_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == st_idle && !start_write) |=> state_reg == st_idle)
      else $error("conversion began without start");
   result_read_a: assert property (@(posedge clock) disable iff (rst)
      result_fetch |=> prdata == {24'h000000, $past(result_reg)})
      else $error("result read wrong");
   irq_wake_a: assert property (@(posedge clock) disable iff (rst)
      (finish && ctrl_reg.irq_enable && !ctrl_write) |=> (conv_irq && wake_request == (wait_mode && !stop_mode)))
      else $error("completion did not raise interrupt");
   read_zero_a: assert property (@(posedge clock) disable iff (rst)
      (psel && !penable && !pwrite && !hit_result && !hit_control) |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   stop_wake_a: assert property (@(posedge clock) disable iff (rst) stop_mode |-> !wake_request)
      else $error("wake raised in stop mode");
endmodule // adc_control_interface

// ==== pkg/adc_ctrl_pkg.sv ====
/*
 Shared constants and types for the converter control block.
 Assumes an APB master with 32-bit data and word-aligned registers.
*/
package adc_ctrl_pkg;
   // =====================================================
   // Register map (offsets not multiples of four: indices)
   localparam logic [7:0] result_index = 8'hd0;
   localparam logic [7:0] control_index = 8'hd1;
   localparam logic [9:0] result_addr = {result_index, 2'b00};
   localparam logic [9:0] control_addr = {control_index, 2'b00};
   // =====================================================
   // Control field positions and reset values of both registers
   localparam int irq_enable_bit = 7;
   localparam int done_flag_bit = 6;
   localparam int start_bit = 5;
   localparam int power_on_bit = 4;
   localparam int osc_disable_bit = 2;
   localparam logic [7:0] control_reset = 8'h40;
   localparam logic [7:0] result_reset = 8'h00;
   // =====================================================
   // Timing
   localparam int clock_mhz = 250;
   localparam int bit_time_ns = 40;
   localparam int bit_cycles = (bit_time_ns * clock_mhz) / 1000;
   localparam int result_bits = 8;

   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_convert = 2'b10
   } conv_state_e;

   typedef struct packed {
      logic irq_enable;
      logic power_on;
      logic osc_disable;
   } ctrl_fields_s;
endpackage

// ==== sim/tb_adc_control_interface.sv ====
/*
 Self-checking bench for the converter control block: APB register
 traffic, conversions against a modelled comparator, low-power modes.
 Assumes the package constants and the two-cycle APB answer.
*/
module tb_adc_control_interface import adc_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals and model state
   localparam int step = 3;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wait_mode = 0, stop_mode = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd, seed = 32'hd14a;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, converter_power, main_osc_disable, conv_irq, wake_request, er, comp_high;
   logic [7:0] dac_code, target = 8'h00;
   int bad_count = 0, compares = 0, cycles = 0;
   int m_ie = 0, m_done = 1, m_pwr = 0, m_osc = 0, m_res = 0;
   // Comparator: trial code above the input voltage reads high
   assign comp_high = dac_code > target;
   adc_control_interface #(.step_cycles(step)) u_adc_control_interface (.clock(clock), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_high(comp_high), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .dac_code(dac_code), .converter_power(converter_power),
      .main_osc_disable(main_osc_disable), .conv_irq(conv_irq), .wake_request(wake_request));
   initial begin
      forever #2 clock = ~clock;
   end
   // ==========================================================
   // Reporting and timeout
   task results;
      $display("counts: bad %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         results();
      end
   end
   task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %0s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %0s got %b expected %b", $time, what, got, exp);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] m_ctrl();
      return {24'h0, m_ie[0], m_done[0], 1'b0, m_pwr[0], 1'b0, m_osc[0], 2'b00};
   endfunction
   // ==========================================================
   // Bus tasks: the edge before setup is always waited, so psel never toggles twice in one step
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task rd_ctrl;
      apb(0, {22'h0, control_addr}, 0);
      chk_word(rd, m_ctrl(), "control");
   endtask
   task wr_ctrl(input logic [7:0] v);
      logic st;
      apb(1, {22'h0, control_addr}, {24'h0, v});
      // Start counts only with power already on and stop low at the write edge
      st = v[5] && m_pwr == 1 && !stop_mode;
      m_ie = v[7]; m_pwr = v[4]; m_osc = v[2];
      if (st) m_done = 0;
   endtask
   task convert;
      int i;
      i = 0;
      do begin
         apb(0, {22'h0, control_addr}, 0);
         i++;
      end while (rd[6] !== 1'b1 && i < 400);
      m_done = 1; m_res = target;
      chk_word(rd, m_ctrl(), "control after conversion");
      apb(0, {22'h0, result_addr}, 0);
      chk_word(rd, m_res, "result");
   endtask
   // ==========================================================
   // Main sequence
   logic [7:0] codes [4];
   initial begin
      repeat (20) @(posedge clock);
      rst <= 0;
      rd_ctrl;
      apb(0, {22'h0, result_addr}, 0);
      chk_word(rd, {24'h0, result_reset}, "result reset");
      apb(0, 32'h0, 0);
      chk_bit(er, 1, "unmapped error");
      chk_word(rd, 0, "unmapped data");
      $display("test reset done");
      wr_ctrl(8'h20);
      rd_ctrl;
      wr_ctrl(8'h14);
      rd_ctrl;
      @(negedge clock);
      chk_bit(converter_power, 1, "power");
      chk_bit(main_osc_disable, 1, "oscillator off");
      wr_ctrl(8'h10);
      rd_ctrl;
      $display("test control done");
      seed = lfsr(seed);
      codes = '{8'h00, 8'hff, seed[7:0], seed[15:8]};
      foreach (codes[k]) begin
         target <= codes[k];
         wr_ctrl(8'h30);
         @(negedge clock);
         chk_word({24'h0, dac_code}, 32'h00000080, "first trial");
         rd_ctrl;
         convert;
         repeat (40) @(posedge clock);
         rd_ctrl;
      end
      seed = lfsr(seed);
      wr_ctrl(8'h30);
      repeat (6) @(posedge clock);
      target <= seed[7:0];
      wr_ctrl(8'h30);
      convert;
      $display("test conversion done");
      wr_ctrl(8'h90);
      wait_mode <= 1;
      @(negedge clock);
      chk_bit(conv_irq, 1, "interrupt level");
      chk_bit(wake_request, 1, "wake in wait");
      stop_mode <= 1;
      @(negedge clock);
      chk_bit(wake_request, 0, "wake in stop");
      wr_ctrl(8'hb0);
      rd_ctrl;
      stop_mode <= 0;
      wr_ctrl(8'hb0);
      @(negedge clock);
      chk_bit(conv_irq, 0, "interrupt withdrawn");
      convert;
      @(negedge clock);
      chk_bit(conv_irq, 1, "interrupt on completion");
      wr_ctrl(8'h10);
      @(negedge clock);
      chk_bit(conv_irq, 0, "interrupt disabled");
      $display("test interrupt done");
      results();
   end
endmodule // tb_adc_control_interface
